/* File: src/wdc_pkg.sv */
package wdc_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int WB_AW = 8;
    localparam int WB_DW = 32;
    localparam int CNT_W = 24;

    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [WB_AW-1:0] OFS_CTRL   = 8'h00;
    localparam logic [WB_AW-1:0] OFS_RELOAD = 8'h04;
    localparam logic [WB_AW-1:0] OFS_COUNT  = 8'h08;
    localparam logic [WB_AW-1:0] OFS_IRQ_ST = 8'h0c;
    localparam logic [WB_AW-1:0] OFS_IRQ_MK = 8'h10;

    // ------------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------------
    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_TO_BIT   = 5;
    localparam int CTRL_STOP_BIT = 6;
    localparam int CTRL_POR_BIT  = 7;

    // interrupt status and mask share one layout
    localparam int IRQ_W        = 2;
    localparam int IRQ_TO_BIT   = 0;
    localparam int IRQ_STOP_BIT = 1;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [CNT_W-1:0] RELOAD_RST = 24'hffffff;
    localparam logic [IRQ_W-1:0] MASK_RST   = 2'h0;

    // timeout_response_select level that picks the interrupt response
    localparam logic RESP_IRQ = 1'b1;

    // ------------------------------------------------------------------
    // bus carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic             cyc;
        logic             stb;
        logic             we;
        logic [WB_AW-1:0] adr;
        logic [3:0]       sel;
        logic [WB_DW-1:0] dat;
    } wdc_wb_req_t;

    typedef struct packed {
        logic             ack;
        logic [WB_DW-1:0] dat;
    } wdc_wb_rsp_t;

endpackage

/* File: src/wdc_tick_sync.sv */
`timescale 1ns/1ps
module wdc_tick_sync (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic osc_in,
    output logic      tick
);
    logic meta;
    logic stable;
    logic last;

    // ------------------------------------------------------------------
    // two-flop synchroniser, then rising edge detect on the second stage
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            meta   <= 1'b0;
            stable <= 1'b0;
            last   <= 1'b0;
            tick   <= 1'b0;
        end else begin
            meta   <= osc_in;
            stable <= meta;
            last   <= stable;
            tick   <= stable & ~last;
        end
    end
endmodule

/* File: src/wdc_down_counter.sv */
`timescale 1ns/1ps
module wdc_down_counter #(
    parameter int WIDTH = 24
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_val,
    input  wire logic             dec,
    output logic      [WIDTH-1:0] count,
    output logic                  reached_zero
);
    // ------------------------------------------------------------------
    // load wins over decrement; zero wraps to all ones on its own
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            count        <= '1;
            reached_zero <= 1'b0;
        end else if (load) begin
            count        <= load_val;
            reached_zero <= 1'b0;
        end else if (dec) begin
            count        <= count - WIDTH'(1);
            reached_zero <= (count == WIDTH'(1));
        end else begin
            reached_zero <= 1'b0;
        end
    end
endmodule

/* File: src/wdc_watchdog.sv */
// How it works
// - on first enable the counter loads the reload register value
// - counter decrements once per watchdog oscillator tick toward zero
// - cpu refresh reloads the counter, counting then resumes
// - debug mode refreshes the counter every cycle, no time-out possible
// - time-out is declared when the counter reaches zero
// - option input selects reset or interrupt response to time-out
// - interrupt mode: raise interrupt request and set time-out flag
// - after interrupt time-out counter wraps to all ones, no reload
// - interrupt mode time-out in stop starts stop recovery plus interrupt
// - interrupt mode time-out in stop sets time-out flag and stop flag
// - reset mode time-out outside stop requests full system reset
// - power-on reset sets the power-on flag in control register
//
// The placing of the registers and register access over Wishbone were decided locally.
`timescale 1ns/1ps
module wdc_watchdog #(
    parameter int CNT_WIDTH = wdc_pkg::CNT_W
) (
    input  wire logic                core_clk,
    input  wire logic                rst,
    input  wire logic                power_on,
    input  wire wdc_pkg::wdc_wb_req_t wb_req,
    output wdc_pkg::wdc_wb_rsp_t     wb_rsp,
    input  wire logic                wdog_osc,
    input  wire logic                refresh,
    input  wire logic                debug_mode,
    input  wire logic                stop_mode,
    input  wire logic                timeout_response_select,
    output logic                     irq,
    output logic                     sys_reset_req,
    output logic                     stop_recovery
);
    import wdc_pkg::*;

    logic                 enable;
    logic                 enable_d;
    logic [CNT_WIDTH-1:0] reload_val;
    logic [CNT_WIDTH-1:0] count;
    logic                 tick;
    logic                 reached_zero;
    logic                 cnt_load;
    logic                 timeout_flag;
    logic                 stop_flag;
    logic                 por_flag;
    logic [IRQ_W-1:0]     irq_status;
    logic [IRQ_W-1:0]     irq_mask;
    logic                 bus_hit;
    logic                 wr_stb;
    logic                 rd_stb;
    logic                 irq_mode;
    logic                 to_irq_ev;
    logic                 to_stop_ev;
    logic                 to_rst_ev;
    logic [IRQ_W-1:0]     irq_events;
    logic [WB_DW-1:0]     next_rdata;

    // ------------------------------------------------------------------
    // wishbone slave: one wait state, ack for one cycle, every address
    // answers so an unmapped access cannot hang the bus
    // ------------------------------------------------------------------
    // writes land at the edge where the master sees ack; reads are
    // captured, and their flags cleared, at the edge that raises ack
    assign bus_hit = wb_req.cyc & wb_req.stb & ~wb_rsp.ack;
    assign wr_stb  = wb_req.cyc & wb_req.stb & wb_req.we & wb_rsp.ack;
    assign rd_stb  = bus_hit & ~wb_req.we;

    always_comb begin
        next_rdata = '0;
        case (wb_req.adr)
            OFS_CTRL: begin
                next_rdata[CTRL_EN_BIT]   = enable;
                next_rdata[CTRL_TO_BIT]   = timeout_flag;
                next_rdata[CTRL_STOP_BIT] = stop_flag;
                next_rdata[CTRL_POR_BIT]  = por_flag;
            end
            OFS_RELOAD: next_rdata[CNT_WIDTH-1:0] = reload_val;
            OFS_COUNT:  next_rdata[CNT_WIDTH-1:0] = count;
            OFS_IRQ_ST: next_rdata[IRQ_W-1:0]     = irq_status;
            OFS_IRQ_MK: next_rdata[IRQ_W-1:0]     = irq_mask;
            default:    next_rdata = '0;
        endcase
    end

    // ack and read data share one process so the response has one driver
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wb_rsp <= '0;
        end else begin
            wb_rsp.ack <= bus_hit;
            if (rd_stb) begin
                wb_rsp.dat <= next_rdata;
            end else begin
                wb_rsp.dat <= '0;
            end
        end
    end

    // ------------------------------------------------------------------
    // software-written registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            enable <= 1'b0;
        end else if (wr_stb && wb_req.adr == OFS_CTRL && wb_req.sel[0]) begin
            enable <= wb_req.dat[CTRL_EN_BIT];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            reload_val <= RELOAD_RST;
        end else if (wr_stb && wb_req.adr == OFS_RELOAD) begin
            for (int b = 0; b < 3; b++) begin
                if (wb_req.sel[b]) begin
                    reload_val[b*8 +: 8] <= wb_req.dat[b*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_mask <= MASK_RST;
        end else if (wr_stb && wb_req.adr == OFS_IRQ_MK && wb_req.sel[0]) begin
            irq_mask <= wb_req.dat[IRQ_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // counting
    // ------------------------------------------------------------------
    wdc_tick_sync u_tick_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .osc_in   (wdog_osc),
        .tick     (tick)
    );

    always_ff @(posedge core_clk) begin
        if (rst) begin
            enable_d <= 1'b0;
        end else begin
            enable_d <= enable;
        end
    end

    // a disabled watchdog ignores refresh and debug; the first enable edge
    // loads the reload value, so counting always starts from that value
    assign cnt_load = (enable & ~enable_d)
                    | (enable & refresh)
                    | (enable & debug_mode);

    wdc_down_counter #(
        .WIDTH (CNT_WIDTH)
    ) u_counter (
        .core_clk     (core_clk),
        .rst          (rst),
        .load         (cnt_load),
        .load_val     (reload_val),
        .dec          (enable & tick),
        .count        (count),
        .reached_zero (reached_zero)
    );

    // ------------------------------------------------------------------
    // time-out response
    // ------------------------------------------------------------------
    // reached_zero is a one-cycle pulse; the counter wraps itself and no
    // reload happens, so the next time-out is a full count later
    assign irq_mode   = (timeout_response_select == RESP_IRQ);
    assign to_irq_ev  = reached_zero & irq_mode;
    assign to_stop_ev = to_irq_ev & stop_mode;
    assign to_rst_ev  = reached_zero & ~irq_mode & ~stop_mode;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sys_reset_req <= 1'b0;
        end else begin
            sys_reset_req <= to_rst_ev;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            stop_recovery <= 1'b0;
        end else begin
            stop_recovery <= to_stop_ev;
        end
    end

    // ------------------------------------------------------------------
    // control register flags: read clears, a new event wins the clear
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            timeout_flag <= 1'b0;
        end else if (to_irq_ev) begin
            timeout_flag <= 1'b1;
        end else if (rd_stb && wb_req.adr == OFS_CTRL) begin
            timeout_flag <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            stop_flag <= 1'b0;
        end else if (to_stop_ev) begin
            stop_flag <= 1'b1;
        end else if (rd_stb && wb_req.adr == OFS_CTRL) begin
            stop_flag <= 1'b0;
        end
    end

    // power_on is sampled during reset too, so the flag survives the
    // system reset that the power-on event itself causes
    always_ff @(posedge core_clk) begin
        if (power_on) begin
            por_flag <= 1'b1;
        end else if (rst) begin
            por_flag <= 1'b0;
        end else if (rd_stb && wb_req.adr == OFS_CTRL) begin
            por_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // interrupt status, mask and request line
    // ------------------------------------------------------------------
    assign irq_events[IRQ_TO_BIT]   = to_irq_ev;
    assign irq_events[IRQ_STOP_BIT] = to_stop_ev;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_status <= '0;
        end else if (rd_stb && wb_req.adr == OFS_IRQ_ST) begin
            irq_status <= irq_events;
        end else begin
            irq_status <= irq_status | irq_events;
        end
    end

    // one cycle behind the status bits, straight from a flop
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

endmodule

/* File: tb/wdc_watchdog_sva.sv */
`timescale 1ns/1ps
module wdc_watchdog_sva (
    input wire logic                 core_clk,
    input wire logic                 rst,
    input wire wdc_pkg::wdc_wb_req_t wb_req,
    input wire wdc_pkg::wdc_wb_rsp_t wb_rsp,
    input wire logic                 debug_mode,
    input wire logic                 stop_mode,
    input wire logic                 timeout_response_select,
    input wire logic                 sys_reset_req,
    input wire logic                 stop_recovery
);
    import wdc_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    a_ack_pulse: assert property (wb_rsp.ack |=> !wb_rsp.ack)
        else $error("ack longer than one cycle");
    a_ack_wait: assert property
        (wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack)
        else $error("ack not one cycle after request");
    a_ack_cause: assert property
        (wb_rsp.ack |-> $past(wb_req.cyc) && $past(wb_req.stb))
        else $error("ack without request");
    a_dat_quiet: assert property (!wb_rsp.ack |-> wb_rsp.dat == '0)
        else $error("read data outside ack");
    a_reset_pulse: assert property (sys_reset_req |=> !sys_reset_req)
        else $error("reset request longer than a pulse");
    a_recov_pulse: assert property (stop_recovery |=> !stop_recovery)
        else $error("recovery longer than a pulse");
    a_reset_mode: assert property
        (sys_reset_req |-> !$past(timeout_response_select)
            && !$past(stop_mode))
        else $error("reset request in wrong mode");
    a_recov_mode: assert property
        (stop_recovery |-> $past(timeout_response_select)
            && $past(stop_mode))
        else $error("recovery in wrong mode");
    a_debug_calm: assert property
        (debug_mode [*4] |-> !sys_reset_req && !stop_recovery)
        else $error("time-out during debug");
endmodule

bind wdc_watchdog wdc_watchdog_sva i_sva (
    .core_clk(core_clk), .rst(rst), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .debug_mode(debug_mode), .stop_mode(stop_mode),
    .timeout_response_select(timeout_response_select),
    .sys_reset_req(sys_reset_req), .stop_recovery(stop_recovery));

/* File: tb/wdc_cpu_model.sv */
`timescale 1ns/1ps
// cpu core and interrupt controller side: issues refresh, counts events
module wdc_cpu_model (
    input wire logic core_clk,
    input wire logic sys_reset_req,
    input wire logic stop_recovery,
    output logic     refresh,
    output int       n_rst,
    output int       n_rec
);
    initial begin
        refresh = 1'b0;
        n_rst = 0;
        n_rec = 0;
    end
    always @(posedge core_clk) begin
        if (sys_reset_req === 1'b1) n_rst <= n_rst + 1;
        if (stop_recovery === 1'b1) n_rec <= n_rec + 1;
    end
    // one refresh instruction lasts one cycle
    task kick;
        @(posedge core_clk) refresh <= 1'b1;
        @(posedge core_clk) refresh <= 1'b0;
    endtask
endmodule

/* File: tb/wdc_watchdog_tb.sv */
`timescale 1ns/1ps
module wdc_watchdog_tb;
    import wdc_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        power_on = 1'b1;
    wdc_wb_req_t req = '0;
    wdc_wb_rsp_t rsp;
    logic        wdog_osc = 1'b0;
    logic        refresh;
    logic        debug_mode = 1'b0;
    logic        stop_mode = 1'b0;
    logic        sel_irq = 1'b1;
    logic        irq;
    logic        sys_reset_req;
    logic        stop_recovery;
    int          n_rst;
    int          n_rec;
    int          failures = 0;
    int          n_checks = 0;

    always #20 core_clk = ~core_clk;

    wdc_watchdog i_dut (.core_clk(core_clk), .rst(rst),
        .power_on(power_on), .wb_req(req), .wb_rsp(rsp),
        .wdog_osc(wdog_osc), .refresh(refresh), .debug_mode(debug_mode),
        .stop_mode(stop_mode), .timeout_response_select(sel_irq),
        .irq(irq), .sys_reset_req(sys_reset_req),
        .stop_recovery(stop_recovery));
    wdc_cpu_model i_cpu (.core_clk(core_clk),
        .sys_reset_req(sys_reset_req), .stop_recovery(stop_recovery),
        .refresh(refresh), .n_rst(n_rst), .n_rec(n_rec));

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
        @(posedge core_clk) req <= '{1'b1, 1'b1, we, a, 4'hf, d};
        do begin
            @(posedge core_clk);
        end while (rsp.ack !== 1'b1);
        q = rsp.dat;
        req <= '0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    // each oscillator period spans nine core cycles, four high and five low
    task osc(input int k);
        repeat (k) begin
            @(posedge core_clk) wdog_osc <= 1'b1;
            repeat (4) @(posedge core_clk);
            wdog_osc <= 1'b0;
            repeat (4) @(posedge core_clk);
        end
        repeat (4) @(posedge core_clk);
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task t_reset;
        rd(OFS_CTRL, 32'h80);
        rd(OFS_CTRL, 32'h0);
        rd(OFS_RELOAD, 32'hffffff);
        rd(OFS_COUNT, 32'hffffff);
        rd(8'h20, 32'h0);
        $display("done t_reset");
    endtask
    task t_count;
        wr(OFS_RELOAD, 32'h3);
        wr(OFS_CTRL, 32'h1);
        rd(OFS_COUNT, 32'h3);
        osc(1);
        rd(OFS_COUNT, 32'h2);
        i_cpu.kick();
        wr(OFS_COUNT, 32'h5);
        rd(OFS_COUNT, 32'h3);
        $display("done t_count");
    endtask
    task t_irq;
        wr(OFS_IRQ_MK, 32'h1);
        osc(3);
        rd(OFS_COUNT, 32'h0);
        chk(irq, 1'b1);
        rd(OFS_CTRL, 32'h21);
        rd(OFS_IRQ_ST, 32'h1);
        repeat (2) @(posedge core_clk);
        chk(irq, 1'b0);
        osc(1);
        rd(OFS_COUNT, 32'hffffff);
        $display("done t_irq");
    endtask
    task t_stop;
        wr(OFS_IRQ_MK, 32'h0);
        stop_mode <= 1'b1;
        i_cpu.kick();
        osc(3);
        chk(n_rec, 1);
        chk(irq, 1'b0);
        wr(OFS_IRQ_MK, 32'h1);
        repeat (2) @(posedge core_clk);
        chk(irq, 1'b1);
        rd(OFS_CTRL, 32'h61);
        rd(OFS_IRQ_ST, 32'h3);
        stop_mode <= 1'b0;
        $display("done t_stop");
    endtask
    task t_rstmode;
        sel_irq <= 1'b0;
        i_cpu.kick();
        osc(3);
        chk(n_rst, 1);
        chk(n_rec, 1);
        stop_mode <= 1'b1;
        i_cpu.kick();
        osc(3);
        chk(n_rst, 1);
        chk(n_rec, 1);
        stop_mode <= 1'b0;
        $display("done t_rstmode");
    endtask
    task t_debug;
        i_cpu.kick();
        debug_mode <= 1'b1;
        osc(4);
        rd(OFS_COUNT, 32'h3);
        chk(n_rst, 1);
        debug_mode <= 1'b0;
        $display("done t_debug");
    endtask

    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        power_on <= 1'b0;
        t_reset();
        t_count();
        t_irq();
        t_stop();
        t_rstmode();
        t_debug();
        complete_run();
    end
    initial begin
        #200000;
        failures++;
        complete_run();
    end
endmodule
